/* tmc_mode_ctrl.v */
// Purpose: static mode and control logic of a multi-channel serial transceiver
// Assumes: pins are asynchronous; datapath lives elsewhere and obeys these controls
// Notes:   all outputs registered; output enables derived from device enable pin
// Timing overview
//    every configuration pin is asynchronous and passes the three-stage
//    synchroniser; a pin change reaches the mode outputs five
//    clock edges later (three stages, agreement, output register).
//    the address straps pass their own synchroniser with the same
//    latency, so the captured address belongs to the same moment as
//    the synchronised chip reset edge that triggers the capture.
//
// Register port
//    offset 0 control: codec enable bit and error flag enable bit.
//    offset 1 status: sticky code violation and disparity flags,
//             write one to clear; a new event beats the clear.
//    offset 2 mode readback: effective modes, chip reset and address.
//    read data stand in the cycle after the strobe and read zero
//    otherwise, so a bus that ors several slaves needs no mux.
//
// Limitations
//    the datapath is outside this block; it is trusted to follow the
//    registered mode outputs one edge after they change.
//    mode changes during traffic are not filtered here; the far side
//    is expected to pulse chip reset after a change so buffers recentre.
`timescale 1ns/10ps
`include "tmc_consts.vh"
module tmc_mode_ctrl #(
   parameter NCH = 8,
   parameter DW  = 10
) (
   // clock and reset
   input  wire                   sys_clk,
   input  wire                   nrst,
   input  wire                   clk_en,
   // configuration pins
   input  wire                   encode_pin,
   input  wire                   error_flag_enable_pin,
   input  wire                   chip_reset_pin,
   input  wire                   serial_loopback_pin,
   input  wire                   rate_select_pin,
   input  wire                   interface_select_pin,
   input  wire                   device_enable_pin,
   input  wire [4:0]             device_address_straps,
   // register port
   input  wire [`TMC_ADDR_W-1:0] reg_addr,
   input  wire [15:0]            reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [15:0]            reg_rdata,
   // decoder results from datapath
   input  wire [NCH*DW-1:0]      dec_data,
   input  wire [NCH-1:0]         dec_code_viol,
   input  wire [NCH-1:0]         dec_disp_err,
   input  wire [NCH*DW-1:0]      enc_data,
   input  wire [NCH-1:0]         serial_rx,
   // data to protocol side
   output reg  [NCH*DW-1:0]      receive_data_bus,
   output reg  [NCH*DW-1:0]      receive_data_oe,
   // decoder input and serial transmit
   output reg  [NCH*DW-1:0]      dec_in_data,
   output reg  [NCH-1:0]         dec_in_serial,
   output reg  [NCH-1:0]         serial_tx,
   output reg  [NCH-1:0]         serial_tx_oe,
   // mode controls to datapath
   output reg                    codec_en,
   output reg                    err_flag_active,
   output reg                    half_rate,
   output reg                    nibble_mode,
   output reg                    loopback_en,
   output reg  [NCH-1:0]         recentre,
   output reg  [4:0]             dev_addr
);
   // =====================================================
   // synchronised pins
   wire [7:0] pin_s;
   reg        rst_pin_d_r;
   reg [15:0] ctrl_r;
   reg [15:0] status_r;

   tmc_sync #(
      .W (8)
   ) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .d_in    ({device_enable_pin, interface_select_pin, rate_select_pin,
                 serial_loopback_pin, chip_reset_pin, error_flag_enable_pin,
                 encode_pin, 1'b0}),
      .d_out   (pin_s)
   );

   // =====================================================
   // address straps; synchronised like every other pin so that
   // a strap still settling at the reset edge cannot go metastable
   wire [4:0] straps_s;

   tmc_sync #(
      .W (5)
   ) u_strap_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .clk_en  (clk_en),
      .d_in    (device_address_straps),
      .d_out   (straps_s)
   );

   // =====================================================
   // synchronised pin names; bit 0 is a spare input tied low, never read
   wire enc_s    = pin_s[1];
   wire eflag_s  = pin_s[2];
   wire crst_s   = pin_s[3];
   wire serial_loopback_pin_s   = pin_s[4];
   wire rate_s   = pin_s[5];
   wire iface_s  = pin_s[6];
   wire enab_s   = pin_s[7];

   // =====================================================
   // combined mode decisions
   wire codec_nxt = enc_s | ctrl_r[`TMC_CTRL_CODEC_BIT];
   wire eflag_nxt = eflag_s | ctrl_r[`TMC_CTRL_ERRFLG_BIT];
   wire subst_en  = eflag_nxt & codec_nxt;

   // substitute all ones on a flagged lane when enabled
   function [DW-1:0] flag_word;
      input [DW-1:0] w;
      input          bad;
      input          en;
      begin
         flag_word = (bad & en) ? {DW{1'b1}} : w;
      end
   endfunction

   // =====================================================
   // register writes; status flags sticky, set wins over a write clear, chip reset clears both
   wire any_cv   = |dec_code_viol;
   wire any_disp = |dec_disp_err;
   always @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_r   <= `TMC_CTRL_RST;
         status_r <= `TMC_STAT_RST;
      end else if (clk_en) begin
         if (reg_wr && reg_addr == `TMC_OFF_CTRL) begin
            ctrl_r <= reg_wdata;
         end
         if (crst_s) begin
            status_r <= `TMC_STAT_RST;
         end else begin
            // write one to clear; a new event in the same cycle survives
            if (reg_wr && reg_addr == `TMC_OFF_STATUS) begin
               status_r <= status_r & ~reg_wdata;
            end
            if (any_cv) begin
               status_r[`TMC_STAT_CV_BIT] <= 1'b1;
            end
            if (any_disp) begin
               status_r[`TMC_STAT_DISP_BIT] <= 1'b1;
            end
         end
      end
   end

   // =====================================================
   // register reads, data valid the cycle after the strobe
   always @(posedge sys_clk) begin
      if (!nrst) begin
         reg_rdata <= 16'h0000;
      end else if (clk_en) begin
         reg_rdata <= 16'h0000;
         if (reg_rd) begin
            case (reg_addr)
               `TMC_OFF_CTRL:   reg_rdata <= ctrl_r;
               `TMC_OFF_STATUS: reg_rdata <= status_r;
               `TMC_OFF_MODE:   reg_rdata <= {3'h0, dev_addr, 2'h0, crst_s, iface_s,
                                              rate_s, serial_loopback_pin_s, eflag_nxt, codec_nxt};
               default:         reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // =====================================================
   // strap capture on rising edge of chip reset
   always @(posedge sys_clk) begin
      if (!nrst) begin
         rst_pin_d_r <= 1'b0;
         dev_addr    <= `TMC_ADDR_RST;
      end else if (clk_en) begin
         rst_pin_d_r <= crst_s;
         // straps share the pin latency, so the value sampled is the one present at the reset edge
         if (crst_s && !rst_pin_d_r) begin
            dev_addr <= straps_s;
         end
      end
   end

   // =====================================================
   // mode outputs and datapath steering
   integer c;
   always @(posedge sys_clk) begin
      if (!nrst) begin
         codec_en         <= 1'b0;
         err_flag_active  <= 1'b0;
         half_rate        <= 1'b0;
         nibble_mode      <= 1'b0;
         loopback_en      <= 1'b0;
         recentre         <= {NCH{1'b0}};
         receive_data_bus <= {NCH*DW{1'b0}};
         receive_data_oe  <= {NCH*DW{1'b0}};
         dec_in_data      <= {NCH*DW{1'b0}};
         dec_in_serial    <= {NCH{1'b0}};
         serial_tx        <= {NCH{1'b0}};
         serial_tx_oe     <= {NCH{1'b0}};
      end else if (clk_en) begin
         codec_en        <= codec_nxt;
         err_flag_active <= eflag_nxt;
         half_rate       <= rate_s;
         nibble_mode     <= iface_s;
         loopback_en     <= serial_loopback_pin_s;
         recentre        <= {NCH{crst_s}};
         // release all pins when device enable is low
         receive_data_oe <= {NCH*DW{enab_s}};
         serial_tx_oe    <= {NCH{enab_s}};
         for (c = 0; c < NCH; c = c + 1) begin
            receive_data_bus[c*DW +: DW] <= flag_word(dec_data[c*DW +: DW],
               dec_code_viol[c] | dec_disp_err[c], subst_en);
            // loopback takes own encoder output, ignores serial input
            dec_in_data[c*DW +: DW] <= serial_loopback_pin_s ? enc_data[c*DW +: DW] : {DW{1'b0}};
            dec_in_serial[c] <= serial_loopback_pin_s ? 1'b0 : serial_rx[c];
            serial_tx[c]     <= serial_loopback_pin_s ? 1'b0 : enc_data[c*DW];
         end
      end
   end
endmodule // tmc_mode_ctrl

/* tmc_consts.vh */
// Purpose: constants for the transceiver mode control block
// Assumes: 10 MHz sys_clk, register port with one-cycle read latency
// Notes:   offsets are word indices on the plain register port
`ifndef TMC_CONSTS_VH
`define TMC_CONSTS_VH

// =====================================================
// register offsets
`define TMC_ADDR_W        4
`define TMC_OFF_CTRL      4'h0
`define TMC_OFF_STATUS    4'h1
`define TMC_OFF_MODE      4'h2

// =====================================================
// control register fields
`define TMC_CTRL_CODEC_BIT   7
`define TMC_CTRL_ERRFLG_BIT  14
`define TMC_CTRL_RST         16'h0000

// =====================================================
// status register fields
`define TMC_STAT_CV_BIT      0
`define TMC_STAT_DISP_BIT    1
`define TMC_STAT_RST         16'h0000

// =====================================================
// mode readback fields
`define TMC_MODE_CODEC_BIT   0
`define TMC_MODE_ERRFLG_BIT  1
`define TMC_MODE_SERIAL_LOOPBACK_PIN_BIT    2
`define TMC_MODE_RATE_BIT    3
`define TMC_MODE_IFACE_BIT   4
`define TMC_MODE_RECTR_BIT   5
`define TMC_MODE_ADDR_LSB    8

// =====================================================
// timing
`define TMC_CLK_NS           100
`define TMC_SYNC_STAGES      3
`define TMC_ADDR_RST         5'h00

`endif

/* tmc_sync.v */
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to sys_clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/10ps
module tmc_sync #(
   parameter W = 1
) (
   // clock and control
   input  wire         sys_clk,
   input  wire         nrst,
   input  wire         clk_en,
   // data
   input  wire [W-1:0] d_in,
   output reg  [W-1:0] d_out
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   integer     i;

   // =====================================================
   // chain; first stage feeds only the second
   always @(posedge sys_clk) begin
      if (!nrst) begin
         s1_r  <= {W{1'b0}};
         s2_r  <= {W{1'b0}};
         s3_r  <= {W{1'b0}};
         d_out <= {W{1'b0}};
      end else if (clk_en) begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // per-bit agreement filters single-cycle glitches
         for (i = 0; i < W; i = i + 1) begin
            if (s2_r[i] == s3_r[i]) begin
               d_out[i] <= s3_r[i];
            end
         end
      end
   end
endmodule // tmc_sync

/* tmc_mode_ctrl_props.sv */
// Purpose: port assertions for the mode control block
// Assumes: clk_en low freezes the block, so checks pause
// Notes:   datapath outputs lag their inputs by one edge
`timescale 1ns/10ps
module tmc_mode_ctrl_props #(
   parameter NCH = 8,
   parameter DW  = 10
) (
   // clock, reset, register port
   input wire sys_clk,
   input wire nrst,
   input wire clk_en,
   input wire [3:0] reg_addr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   // datapath and modes
   input wire [NCH*DW-1:0] dec_data,
   input wire [NCH-1:0] dec_code_viol,
   input wire [NCH-1:0] dec_disp_err,
   input wire [NCH*DW-1:0] enc_data,
   input wire [NCH*DW-1:0] receive_data_bus,
   input wire [NCH*DW-1:0] receive_data_oe,
   input wire [NCH*DW-1:0] dec_in_data,
   input wire [NCH-1:0] dec_in_serial,
   input wire [NCH-1:0] serial_tx,
   input wire [NCH-1:0] serial_tx_oe,
   input wire codec_en,
   input wire err_flag_active,
   input wire loopback_en,
   input wire [NCH-1:0] recentre
);
   // ==============================
   // low lanes stand for all lanes
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst || !clk_en);
   chk_bad_word_ones: assert property (
      (dec_code_viol[0] || dec_disp_err[0]) ##1 (codec_en && err_flag_active)
      |-> receive_data_bus[DW-1:0] == {DW{1'b1}}) else $error("bad word not flagged");
   chk_unflagged_pass: assert property (
      (dec_code_viol[0] || dec_disp_err[0]) ##1 !(codec_en && err_flag_active)
      |-> receive_data_bus[DW-1:0] == $past(dec_data[DW-1:0])) else $error("word altered");
   chk_clean_pass: assert property (!dec_code_viol[1] && !dec_disp_err[1]
      |=> receive_data_bus[2*DW-1:DW] == $past(dec_data[2*DW-1:DW])) else $error("clean word altered");
   chk_loop_data: assert property (1'b1 ##1 loopback_en
      |-> dec_in_data == $past(enc_data)) else $error("loop data wrong");
   chk_loop_quiet: assert property (loopback_en |-> serial_tx == '0 && dec_in_serial == '0)
      else $error("loop not quiet");
   chk_oe_together: assert property (receive_data_oe == {(NCH*DW){serial_tx_oe[0]}}
      && serial_tx_oe == {NCH{serial_tx_oe[0]}}) else $error("enables split");
   chk_status_clear: assert property (recentre[0] [*2] ##0 (reg_rd && reg_addr == 4'h1)
      |=> reg_rdata == 16'h0000) else $error("status kept");
   chk_recentre_all: assert property (recentre == '0 || recentre == '1)
      else $error("recentre split");
endmodule // tmc_mode_ctrl_props

/* tmc_dp_model.sv */
// Purpose: datapath stand-in feeding decoder and encoder words
// Assumes: error masks come from the bench
// Notes:   words change every clock so stale data shows
`timescale 1ns/10ps
module tmc_dp_model (
   // clock and error requests
   input wire sys_clk,
   input wire [7:0] viol_mask,
   input wire [7:0] disp_mask,
   // datapath words
   output wire [79:0] dec_data,
   output wire [7:0] dec_code_viol,
   output wire [7:0] dec_disp_err,
   output wire [79:0] enc_data,
   output wire [7:0] serial_rx
);
   logic [8:0] cnt_r = 9'h000;
   // top bit held low so a clean word never reads all ones
   always @(posedge sys_clk) cnt_r <= cnt_r + 9'h001;
   assign dec_data = {8{1'b0, cnt_r}};
   assign enc_data = ~dec_data;
   assign serial_rx = cnt_r[7:0];
   assign dec_code_viol = viol_mask;
   assign dec_disp_err = disp_mask;
endmodule // tmc_dp_model

/* tmc_mode_ctrl_tb_top.sv */
// Purpose: self-checking bench for the mode control block
// Assumes: pin changes settle within 8 clocks
// Notes:   one task per scenario
`timescale 1ns/10ps
module tmc_mode_ctrl_tb_top;
   // ==============================
   // stimulus and observed signals
   logic sys_clk = 1'b0, nrst = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic encode_pin = 1'b0, error_flag_enable_pin = 1'b0, chip_reset_pin = 1'b0;
   logic serial_loopback_pin = 1'b0, rate_select_pin = 1'b0, interface_select_pin = 1'b0;
   logic device_enable_pin = 1'b1, codec_en, err_flag_active, half_rate, nibble_mode, loopback_en;
   logic [3:0] reg_addr = 4'h0;
   logic [4:0] device_address_straps = 5'h15, dev_addr;
   logic [15:0] reg_wdata = 16'h0000, reg_rdata;
   logic [7:0] viol_mask = 8'h00, disp_mask = 8'h00, dec_code_viol, dec_disp_err, serial_rx;
   logic [7:0] dec_in_serial, serial_tx, serial_tx_oe, recentre;
   logic [79:0] dec_data, enc_data, receive_data_bus, receive_data_oe, dec_in_data, snap;
   int mismatches = 0, compares = 0;
   always #50 sys_clk = ~sys_clk;
   tmc_mode_ctrl #(.NCH(8), .DW(10)) tmc_mode_ctrl_i (.*);
   tmc_dp_model tmc_dp_model_i (.*);
   // ==============================
   // pins: encode, flag, chip reset, loopback, rate, iface, enable
   task automatic pins(input logic [6:0] p);
      @(posedge sys_clk);
      {encode_pin, error_flag_enable_pin, chip_reset_pin, serial_loopback_pin,
       rate_select_pin, interface_select_pin, device_enable_pin} <= p;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic chk(input logic [79:0] got, input logic [79:0] exp);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
      @(posedge sys_clk);
      {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // ==============================
   // scenarios
   task automatic t_codec;
      for (int i = 0; i < 4; i++) begin
         wr(4'h0, {8'h00, i[1], 7'h00});
         pins({i[0], 6'h01});
         chk(codec_en, i[0] | i[1]);
      end
   endtask
   task automatic t_flag;
      @(posedge sys_clk);
      {viol_mask, disp_mask} <= 16'h0120;
      wr(4'h0, 16'h0080);
      pins(7'h21);
      chk({receive_data_bus[59:50], receive_data_bus[9:0]}, 20'hfffff);
      wr(4'h0, 16'h4000);
      pins(7'h01);
      chk({codec_en, err_flag_active}, 2'b01);
      @(negedge sys_clk) snap = dec_data;
      @(negedge sys_clk) chk(receive_data_bus, snap);
      @(posedge sys_clk);
      {viol_mask, disp_mask} <= 16'h0000;
   endtask
   task automatic t_modes;
      for (int i = 0; i < 4; i++) begin
         pins({4'h0, i[1:0], 1'b1});
         chk({half_rate, nibble_mode}, i[1:0]);
      end
   endtask
   // straps move after the rising edge, address must not follow
   task automatic t_reset;
      rdc(4'h1, 16'h0003);
      pins(7'h11);
      chk(recentre, 8'hff);
      rdc(4'h1, 16'h0000);
      @(posedge sys_clk);
      device_address_straps <= 5'h0a;
      pins(7'h01);
      chk({recentre, 3'h0, dev_addr}, 16'h0015);
      rdc(4'hf, 16'h0000);
      rdc(4'h0, 16'h4000);
      rdc(4'h2, 16'h1502);
   endtask
   // clock enable low must freeze every flop, synchroniser included
   task automatic t_freeze;
      @(posedge sys_clk);
      clk_en <= 1'b0;
      pins(7'h05);
      chk(half_rate, 1'b0);
      clk_en <= 1'b1;
      repeat (8) @(posedge sys_clk);
      #1 chk(half_rate, 1'b1);
      pins(7'h01);
   endtask
   task automatic t_loop;
      pins(7'h09);
      @(negedge sys_clk) snap = enc_data;
      @(negedge sys_clk) chk(dec_in_data, snap);
      chk({serial_tx, dec_in_serial}, 16'h0000);
      chk(loopback_en, 1'b1);
      pins(7'h01);
      chk(loopback_en, 1'b0);
      @(negedge sys_clk) snap = {enc_data[71:0], serial_rx};
      @(negedge sys_clk) chk(dec_in_serial, snap[7:0]);
      chk(serial_tx, {8{snap[8]}});
   endtask
   task automatic t_enable;
      pins(7'h00);
      chk({serial_tx_oe, receive_data_oe[71:0]}, 80'h0);
      pins(7'h01);
      chk(receive_data_oe & {{72{1'b1}}, serial_tx_oe}, {80{1'b1}});
   endtask
   task automatic test_done;
      $display("mismatches %0d, compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      nrst <= 1'b1;
      t_codec;
      t_flag;
      t_modes;
      t_reset; // recentre after mode changes
      t_loop;
      t_freeze;
      t_enable;
      test_done;
   end
endmodule // tmc_mode_ctrl_tb_top
bind tmc_mode_ctrl tmc_mode_ctrl_props #(.NCH(NCH), .DW(DW)) tmc_mode_ctrl_props_i (.*);
